// ### rtl/daq_trigger_and_limit_output.sv
// Purpose: Trigger, stop, acquisition mode and output timing logic
// Assumes: Scan sequencer supplies samples; analog trigger comparator pin
// Notes:
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module daq_trigger_and_limit_output
   import daq_trig_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   input  wire sample_t     smp_in,
   input  wire logic        conv_tick_in,
   input  wire logic        dma_valid_in,
   input  wire logic [63:0] dma_ao_in,
   input  wire logic [15:0] dma_do_in,
   input  wire logic        atrig_cmp_in,
   input  wire logic        dtrig_pin_in,
   input  wire logic [PAT_W-1:0] din_in,
   input  wire logic [127:0] counters_in,
   input  wire logic        sw_stop_in,
   output logic             dma_ready_out,
   output logic [63:0]      ao_out,
   output logic [15:0]      do_out,
   output logic             update_out,
   output logic [15:0]      atrig_level_out,
   output logic [5:0]       atrig_chan_out,
   output logic             store_out,
   output logic             trig_out,
   output logic             stop_out,
   output logic [15:0]      ctl_stat_out
);
   // =====================================================
   // Registers
   logic [4:0]   ctrl;
   logic [31:0]  period;
   logic [63:0]  ao_host;
   logic [15:0]  do_host;
   logic [31:0]  trig_cfg;
   logic [31:0]  level;
   logic [31:0]  pattern;
   logic [31:0]  cnt_lo;
   logic [31:0]  cnt_hi;
   logic [31:0]  pre_cnt;
   logic [31:0]  stop_cnt;
   logic [31:0]  lim_words [0:N_LIM*4-1];
   logic [N_LIM-1:0] lim_above;
   logic [15:0]  lim_val [0:N_LIM-1];
   acq_state_t   state;
   logic [31:0]  pace_cnt;
   logic [31:0]  pre_seen;
   logic [31:0]  scan_seen;
   logic         trig_seen;
   logic         stop_seen;
   logic [2:0]   dsync;
   logic [2:0]   async_s;
   logic         dtrig_q;
   logic         acmp_q;
   logic         pend;

   // =====================================================
   // Decode
   wire         ao_wr_hit  = wr_in && addr_in == REG_AO_WR;
   wire         do_wr_hit  = wr_in && addr_in == REG_DO_WR;
   wire         lim_hit    = addr_in >= REG_LIM_BASE && addr_in <= REG_LIM_LAST;
   wire [7:0]   lim_idx    = addr_in - REG_LIM_BASE;
   wire         sync_mode  = ctrl[CTRL_SYNC];
   wire         limit_en   = ctrl[CTRL_LIMEN];
   wire         arm_wr     = wr_in && addr_in == REG_CTRL
                             && wdata_in[CTRL_ARM];
   wire         halt_wr    = wr_in && addr_in == REG_CTRL
                             && wdata_in[CTRL_HALT];
   wire trig_src_t src     = trig_src_t'(trig_cfg[1:0]);
   wire dig_mode_t dmode   = dig_mode_t'(trig_cfg[3:2]);
   wire cnt_mode_t cmode   = cnt_mode_t'(trig_cfg[5:4]);
   wire pre_mode_t pmode   = pre_mode_t'(trig_cfg[7:6]);
   wire [1:0]   cnt_sel    = trig_cfg[9:8];
   wire         a_rise     = trig_cfg[10];
   wire [15:0]  pat_mask   = pattern[31:16];
   wire [31:0]  cnt_val    = counters_in[cnt_sel*32 +: 32];
   wire         eff_period_ok = period >= MIN_UPDATE_CYC;

   // =====================================================
   // Output pacing
   wire pace_done = pace_cnt == 32'h0000_0000;
   wire int_tick  = pace_done && dma_valid_in;
   wire tick      = sync_mode && dma_valid_in
                    && (ctrl[CTRL_INPACE] ? conv_tick_in : int_tick);

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         pace_cnt <= 32'h0000_0000;
      else if (tick)
         pace_cnt <= (eff_period_ok ? period : MIN_UPDATE_CYC) - 32'h1;
      else if (!pace_done)
         pace_cnt <= pace_cnt - 32'h1;
   end

   // =====================================================
   // Register writes
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         ctrl     <= 5'h00;
         period   <= 32'h0000_0000;
         ao_host  <= 64'h0;
         do_host  <= 16'h0000;
         trig_cfg <= 32'h0000_0000;
         level    <= 32'h0000_0000;
         pattern  <= 32'h0000_0000;
         cnt_lo   <= 32'h0000_0000;
         cnt_hi   <= 32'h0000_0000;
         pre_cnt  <= 32'h0000_0000;
         stop_cnt <= 32'h0000_0000;
      end
      else if (wr_in)
      begin
         case (addr_in)
            REG_CTRL:     ctrl <= {wdata_in[CTRL_LIMEN], 2'b00,
                                   wdata_in[CTRL_INPACE:CTRL_SYNC]};
            REG_PERIOD:   period <= wdata_in * STEP_CYC;
            REG_AO_WR:    ao_host[wdata_in[17:16]*16 +: 16] <= wdata_in[15:0];
            REG_DO_WR:    do_host <= wdata_in[15:0];
            REG_TRIG_CFG: trig_cfg <= wdata_in;
            REG_LEVEL:    level <= wdata_in;
            REG_PATTERN:  pattern <= wdata_in;
            REG_CNT_LO:   cnt_lo <= wdata_in;
            REG_CNT_HI:   cnt_hi <= wdata_in;
            REG_PRE_CNT:  pre_cnt <= wdata_in;
            REG_STOP_CNT: stop_cnt <= wdata_in;
            default:      ctrl <= ctrl;
         endcase
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         for (int k = 0; k < N_LIM*4; k++)
            lim_words[k] <= 32'h0000_0000;
      end
      else if (wr_in && lim_hit)
         lim_words[lim_idx[5:0]] <= wdata_in;
   end

   // =====================================================
   // Limit cells
   genvar gi;
   generate
      for (gi = 0; gi < N_LIM; gi++)
      begin : g_lim
         limit_cfg_t cfg;
         assign cfg = {lim_words[gi*4][7:0], lim_words[gi*4+1],
                       lim_words[gi*4+2]};
         limit_cell u_cell (
            .clock_in   (clock_in),
            .sys_rst_in (sys_rst_in),
            .en_in      (limit_en),
            .cfg_in     (cfg),
            .smp_in     (smp_in),
            .above_out  (lim_above[gi]),
            .value_out  (lim_val[gi])
         );
      end
   endgenerate

   // =====================================================
   // Trigger inputs
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         dsync   <= 3'b000;
         async_s <= 3'b000;
         dtrig_q <= 1'b0;
         acmp_q  <= 1'b0;
      end
      else
      begin
         dsync   <= {dsync[1:0], dtrig_pin_in};
         async_s <= {async_s[1:0], atrig_cmp_in};
         if (dsync[2] == dsync[1]) dtrig_q <= dsync[2];
         if (async_s[2] == async_s[1]) acmp_q <= async_s[2];
      end
   end

   wire d_new = (dsync[2] == dsync[1]) ? dsync[2] : dtrig_q;
   wire a_new = (async_s[2] == async_s[1]) ? async_s[2] : acmp_q;
   logic dig_hit;
   always_comb
   begin
      case (dmode)
         DT_HIGH: dig_hit = d_new;
         DT_LOW:  dig_hit = !d_new;
         DT_RISE: dig_hit = d_new && !dtrig_q;
         DT_FALL: dig_hit = !d_new && dtrig_q;
         default: dig_hit = 1'b0;
      endcase
   end
   wire ana_hit = a_rise ? (a_new && !acmp_q) : (!a_new && acmp_q);
   wire pat_hit = ((din_in ^ pattern[15:0]) & ~pat_mask) == 16'h0000;
   logic cnt_hit;
   always_comb
   begin
      case (cmode)
         CM_REACH:  cnt_hit = cnt_val == cnt_lo;
         CM_EXCEED: cnt_hit = cnt_val > cnt_lo;
         CM_WINDOW: cnt_hit = cnt_val >= cnt_lo && cnt_val <= cnt_hi;
         default:   cnt_hit = 1'b0;
      endcase
   end
   logic trig_hit;
   always_comb
   begin
      case (src)
         SRC_ANALOG:  trig_hit = ana_hit;
         SRC_DIGITAL: trig_hit = dig_hit;
         SRC_PATTERN: trig_hit = pat_hit;
         SRC_COUNTER: trig_hit = cnt_hit;
         default:     trig_hit = 1'b0;
      endcase
   end
   wire has_pre   = pmode == PM_PRE_STOP || pmode == PM_PRE_INF;
   wire stop_mode = pmode == PM_NONE_STOP || pmode == PM_PRE_STOP;
   wire scan_stop = stop_cnt != 32'h0 && scan_seen >= stop_cnt;
   wire stop_hit  = stop_mode && (sw_stop_in || scan_stop);

   // =====================================================
   // Acquisition sequencer
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state     <= ST_IDLE;
         pre_seen  <= 32'h0;
         scan_seen <= 32'h0;
         trig_seen <= 1'b0;
         stop_seen <= 1'b0;
      end
      else if (arm_wr)
      begin
         state     <= has_pre ? ST_PRE : ST_WAIT;
         pre_seen  <= 32'h0;
         scan_seen <= 32'h0;
         trig_seen <= 1'b0;
         stop_seen <= 1'b0;
      end
      else
      begin
         case (state)
            ST_PRE:
            begin
               if (smp_in.valid) pre_seen <= pre_seen + 32'h1;
               if (halt_wr) state <= ST_DONE;
               else if (pre_seen + 32'h1 >= pre_cnt && smp_in.valid)
                  state <= ST_RUN;
            end
            ST_WAIT:
            begin
               if (halt_wr) state <= ST_DONE;
               else if (trig_hit && !trig_seen)
               begin
                  trig_seen <= 1'b1;
                  state     <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               if (smp_in.valid) scan_seen <= scan_seen + 32'h1;
               if (halt_wr) state <= ST_DONE;
               else if (stop_hit && !stop_seen)
               begin
                  stop_seen <= 1'b1;
                  state     <= ST_DONE;
               end
            end
            ST_IDLE: state <= ST_IDLE;
            ST_DONE: state <= ST_DONE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // =====================================================
   // Outputs
   logic [63:0] next_ao;
   logic [15:0] next_do;
   logic [15:0] next_stat;
   always_comb
   begin
      next_ao   = sync_mode ? dma_ao_in : ao_host;
      next_do   = sync_mode ? dma_do_in : do_host;
      next_stat = {4'h0, lim_above};
      if (limit_en)
      begin
         for (int i = 0; i < N_AO; i++)
            next_ao[i*16 +: 16] = lim_val[N_DO+i];
         for (int i = 0; i < N_DO; i++)
            next_do[i] = lim_val[i][0];
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         ao_out          <= 64'h0;
         do_out          <= 16'h0000;
         update_out      <= 1'b0;
         dma_ready_out   <= 1'b0;
         atrig_level_out <= 16'h0000;
         atrig_chan_out  <= 6'h00;
         store_out       <= 1'b0;
         trig_out        <= 1'b0;
         stop_out        <= 1'b0;
         ctl_stat_out    <= 16'h0000;
         rdata_out       <= 32'h0000_0000;
         pend            <= 1'b0;
      end
      else
      begin
         pend <= ao_wr_hit || do_wr_hit;
         if (tick || limit_en || (!sync_mode && pend))
         begin
            ao_out <= next_ao;
            do_out <= next_do;
         end
         update_out      <= tick || (!sync_mode && pend);
         dma_ready_out   <= tick;
         atrig_level_out <= level[15:0];
         atrig_chan_out  <= trig_cfg[21:16];
         store_out       <= state == ST_RUN || state == ST_PRE;
         trig_out        <= state == ST_WAIT && trig_hit && !trig_seen;
         stop_out        <= state == ST_RUN && stop_hit && !stop_seen;
         ctl_stat_out    <= next_stat;
         if (rd_in)
         begin
            case (addr_in)
               REG_CTRL:     rdata_out <= {27'h0, ctrl};
               REG_PERIOD:   rdata_out <= period;
               REG_TRIG_CFG: rdata_out <= trig_cfg;
               REG_LEVEL:    rdata_out <= level;
               REG_PATTERN:  rdata_out <= pattern;
               REG_CNT_LO:   rdata_out <= cnt_lo;
               REG_CNT_HI:   rdata_out <= cnt_hi;
               REG_PRE_CNT:  rdata_out <= pre_cnt;
               REG_STOP_CNT: rdata_out <= stop_cnt;
               REG_STATUS:   rdata_out <= {26'h0, stop_seen, trig_seen,
                                           1'b0, 3'(state)};
               REG_CTL_STAT: rdata_out <= {16'h0, next_stat};
               default:      rdata_out <= 32'h0000_0000;
            endcase
         end
         else
            rdata_out <= 32'h0000_0000;
      end
   end

   chk_trig_once: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      trig_out |=> !trig_out [*2])
      else $error("trigger reported twice");
   chk_stop_ends: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (state == ST_RUN && stop_hit && !stop_seen && !arm_wr && !halt_wr)
      |=> state == ST_DONE ##1 !store_out)
      else $error("stop did not end storing");
   chk_pace_min: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (tick && !ctrl[CTRL_INPACE]) |=> !tick [*8])
      else $error("update period too short");
   chk_halt_ends: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (halt_wr && !arm_wr && (state == ST_PRE || state == ST_WAIT
       || state == ST_RUN)) |=> state == ST_DONE)
      else $error("halt did not end acquisition");
   chk_async_update: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (!sync_mode && pend) |=> update_out)
      else $error("host write did not update outputs");
endmodule

// ### rtl/daq_trig_pkg.sv
// Purpose: Shared constants and types for the trigger and output timing block
// Assumes: 250 MHz system clock, plain register port
// Notes:   Offsets are word indices on the register port
package daq_trig_pkg;
   // =====================================================
   // Timing
   localparam int  CLK_PERIOD_PS    = 4000;
   localparam int  TICK_STEP_PS     = 20830;
   localparam int  MIN_UPDATE_NS    = 1000;
   localparam int  MIN_UPDATE_CYC   = (MIN_UPDATE_NS * 1000 + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
   localparam int  STEP_CYC         = (TICK_STEP_PS + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
   // =====================================================
   // Register offsets
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_PERIOD    = 8'h01;
   localparam logic [7:0] REG_AO_WR     = 8'h02;
   localparam logic [7:0] REG_DO_WR     = 8'h03;
   localparam logic [7:0] REG_TRIG_CFG  = 8'h04;
   localparam logic [7:0] REG_LEVEL     = 8'h05;
   localparam logic [7:0] REG_PATTERN   = 8'h06;
   localparam logic [7:0] REG_CNT_LO    = 8'h07;
   localparam logic [7:0] REG_CNT_HI    = 8'h08;
   localparam logic [7:0] REG_PRE_CNT   = 8'h09;
   localparam logic [7:0] REG_STOP_CNT  = 8'h0a;
   localparam logic [7:0] REG_STATUS    = 8'h0b;
   localparam logic [7:0] REG_CTL_STAT  = 8'h0c;
   localparam logic [7:0] REG_LIM_BASE  = 8'h10;
   localparam logic [7:0] REG_LIM_LAST  = 8'h3f;
   // =====================================================
   // Control bits
   localparam int CTRL_SYNC   = 0;
   localparam int CTRL_INPACE = 1;
   localparam int CTRL_ARM    = 2;
   localparam int CTRL_HALT   = 3;
   localparam int CTRL_LIMEN  = 4;
   // =====================================================
   // Counts
   localparam int N_DO     = 8;
   localparam int N_AO     = 4;
   localparam int N_LIM    = N_DO + N_AO;
   localparam int N_CH     = 64;
   localparam int N_CNT    = 4;
   localparam int PAT_W    = 16;
   typedef enum {ST_IDLE, ST_PRE, ST_WAIT, ST_RUN, ST_DONE} acq_state_t;
   typedef enum logic [1:0] {
      SRC_ANALOG, SRC_DIGITAL, SRC_PATTERN, SRC_COUNTER} trig_src_t;
   typedef enum logic [1:0] {
      DT_HIGH, DT_LOW, DT_RISE, DT_FALL} dig_mode_t;
   typedef enum logic [1:0] {
      CM_REACH, CM_EXCEED, CM_WINDOW} cnt_mode_t;
   typedef enum logic [1:0] {
      PM_NONE_STOP, PM_PRE_STOP, PM_NONE_INF, PM_PRE_INF} pre_mode_t;
   // Scanned sample as it leaves the sequencer
   typedef struct packed {
      logic        valid;
      logic [1:0]  kind;
      logic [5:0]  chan;
      logic [31:0] value;
   } sample_t;
   // Limit entry: source, limit, hysteresis, two outputs
   typedef struct packed {
      logic [1:0]  kind;
      logic [5:0]  chan;
      logic [15:0] limit;
      logic [15:0] hyst;
      logic [15:0] val_above;
      logic [15:0] val_below;
   } limit_cfg_t;
endpackage

// ### rtl/limit_cell.sv
// Purpose: One limit comparison with hysteresis
// Assumes: Samples arrive as a one-cycle valid from the scan
// Notes:   State changes on the sample's cycle, output next edge
`timescale 1ns/1ps
module limit_cell
   import daq_trig_pkg::*;
(
   input  wire logic       clock_in,
   input  wire logic       sys_rst_in,
   input  wire logic       en_in,
   input  wire limit_cfg_t cfg_in,
   input  wire sample_t    smp_in,
   output logic            above_out,
   output logic [15:0]     value_out
);
   // ==================================================
   // Compare
   wire        hit   = en_in && smp_in.valid && smp_in.kind == cfg_in.kind
                       && smp_in.chan == cfg_in.chan;
   wire [16:0] hi_th = {1'b0, cfg_in.limit} + {1'b0, cfg_in.hyst};
   wire [16:0] lo_th = {1'b0, cfg_in.limit} - {1'b0, cfg_in.hyst};
   wire [16:0] v     = {1'b0, smp_in.value[15:0]};
   wire        go_up = v > hi_th;
   wire        go_dn = lo_th[16] ? 1'b0 : v < lo_th;

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         above_out <= 1'b0;
         value_out <= 16'h0000;
      end
      else
      begin
         if (hit && go_up) above_out <= 1'b1;
         else if (hit && go_dn) above_out <= 1'b0;
         value_out <= above_out ? cfg_in.val_above : cfg_in.val_below;
      end
   end

   chk_hyst_hold: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (hit && !go_up && !go_dn) |=> above_out == $past(above_out))
      else $error("limit output moved inside hysteresis band");
endmodule

// ### dv/dma_source.sv
// Purpose: DMA word source standing in for host memory
// Assumes: One word handed over per ready pulse
// Notes:   Word n carries n on every lane
`timescale 1ns/1ps
module dma_source
(
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        ready_in,
   output logic             valid_out,
   output logic [63:0]      ao_out,
   output logic [15:0]      do_out
);
   logic [15:0] word;
   // ==========================================
   // Word stream, advanced on each consumed word
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         word <= 16'h0001;
      else if (ready_in)
         word <= word + 16'h0001;
   end
   assign valid_out = !sys_rst_in;
   assign do_out    = word;
   assign ao_out    = {4{word}};
endmodule

// ### dv/daq_trigger_and_limit_output_bench.sv
// Purpose: Self-checking bench for trigger and output timing
// Assumes: DMA words come from dma_source
// Notes:   Row table first, then hand-written cases
`timescale 1ns/1ps
module daq_trigger_and_limit_output_bench;
   import daq_trig_pkg::*;
   typedef struct packed
   {
      logic [7:0]  a;
      logic [31:0] d;
      logic [79:0] e;
   } row_t;
   logic         clock_in = 1'h0, sys_rst_in = 1'h1, wr_in = 1'h0;
   logic         rd_in = 1'h0, sw_stop_in = 1'h0, conv_tick_in = 1'h0;
   logic         atrig_cmp_in = 1'h0, dtrig_pin_in = 1'h0, lv;
   logic [7:0]   addr_in = 8'h00;
   logic [31:0]  wdata_in = 32'h0, r, rdata_out;
   logic [15:0]  din_in = 16'h0, d1, do_out, dma_do_in;
   logic [15:0]  ctl_stat_out, atrig_level_out;
   logic [127:0] counters_in = 128'h0;
   sample_t      smp_in = '0;
   logic         dma_valid_in, dma_ready_out, update_out;
   logic         store_out, trig_out, stop_out;
   logic [63:0]  dma_ao_in, ao_out;
   logic [5:0]   atrig_chan_out;
   int           err_total = 0, cmp_count = 0, i, t;
   int           pv [2] = '{1, 50};
   int           pe [2] = '{250, 300};
   row_t         rows [4] = '{
      '{REG_DO_WR, 32'h0000a5c3, {64'h0, 16'ha5c3}},
      '{REG_AO_WR, 32'h00001234, {64'h1234, 16'ha5c3}},
      '{REG_AO_WR, 32'h0003beef, {64'hbeef000000001234, 16'ha5c3}},
      '{REG_DO_WR, 32'h0000ffff, {64'hbeef000000001234, 16'hffff}}};

   always #2 clock_in = ~clock_in;

   daq_trigger_and_limit_output dut (.clock_in, .sys_rst_in, .addr_in,
      .wdata_in, .wr_in, .rd_in, .rdata_out, .smp_in, .conv_tick_in,
      .dma_valid_in, .dma_ao_in, .dma_do_in, .atrig_cmp_in, .dtrig_pin_in,
      .din_in, .counters_in, .sw_stop_in, .dma_ready_out, .ao_out,
      .do_out, .update_out, .atrig_level_out, .atrig_chan_out, .store_out,
      .trig_out, .stop_out, .ctl_stat_out);
   dma_source src (.clock_in, .sys_rst_in, .ready_in(dma_ready_out),
      .valid_out(dma_valid_in), .ao_out(dma_ao_in), .do_out(dma_do_in));

   // ==========================================
   // Tasks
   task give_verdict();
      $display("errors %0d checks %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string n, input logic [79:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         err_total++;
      end
   endtask
   task step();
      @(posedge clock_in);
      #1;
   endtask
   task automatic hit(ref logic s, input int n, input string nm);
      for (t = 0; t < n && s !== 1'b1; t++)
         step();
      chk(nm, 80'h1, {79'h0, s});
      if (s !== 1'b1)
         give_verdict();
   endtask
   task automatic quiet(ref logic s, input int n, input string nm);
      repeat (n)
      begin
         step();
         chk(nm, 80'h0, {79'h0, s});
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1;
      r = rdata_out;
   endtask
   task arm(input logic [31:0] c);
      wr(REG_TRIG_CFG, c);
      wr(REG_CTRL, 32'h4);
   endtask
   task stop_pulse();
      @(posedge clock_in);
      sw_stop_in <= 1'b1;
      @(posedge clock_in);
      sw_stop_in <= 1'b0;
      #1;
   endtask
   task smp(input logic [31:0] v);
      @(posedge clock_in);
      smp_in <= '{1'b1, 2'h0, 6'h03, v};
      @(posedge clock_in);
      smp_in.valid <= 1'b0;
      repeat (3) step();
   endtask

   // ==========================================
   // Sequence
   initial
   begin
      repeat (4) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      step();
      chk("reset outs", 80'h0, {ao_out, do_out});
      for (i = 0; i < 4; i++)
      begin
         wr(rows[i].a, rows[i].d);
         hit(update_out, 10, "update");
         chk("ao do", rows[i].e, {ao_out, do_out});
      end
      rd(8'hff);
      chk("unmapped", 80'h0, r);
      for (i = 0; i < 4; i++)
      begin
         lv = (i == 1 || i == 3);
         @(posedge clock_in);
         dtrig_pin_in <= lv;
         arm(32'(i * 4 + 1));
         quiet(trig_out, 12, "early trig");
         @(posedge clock_in);
         dtrig_pin_in <= !lv;
         hit(trig_out, 250, "dig trig");
         hit(store_out, 4, "store on");
         quiet(trig_out, 12, "retrig");
         stop_pulse();
         hit(stop_out, 10, "stop");
         repeat (3) step();
         chk("store off", 80'h0, store_out);
      end
      wr(REG_LEVEL, 32'h00007abc);
      arm(32'h00280480);
      chk("trig chan", 80'h28, atrig_chan_out);
      chk("trig level", 80'h7abc, atrig_level_out);
      quiet(trig_out, 12, "early ana");
      @(posedge clock_in);
      atrig_cmp_in <= 1'b1;
      hit(trig_out, 250, "ana trig");
      stop_pulse();
      quiet(stop_out, 10, "inf stop");
      chk("inf store", 80'h1, store_out);
      wr(REG_CTRL, 32'h8);
      repeat (3) step();
      chk("halt store", 80'h0, store_out);
      wr(REG_PATTERN, 32'hff0000ff);
      wr(REG_STOP_CNT, 32'h3);
      din_in <= 16'h00fe;
      arm(32'h2);
      quiet(trig_out, 12, "early pat");
      din_in <= 16'h12ff;
      hit(trig_out, 20, "pat trig");
      smp(32'h1);
      smp(32'h1);
      chk("scan stop early", 80'h0, stop_out);
      smp(32'h1);
      chk("scan stop", 80'h0, store_out);
      wr(REG_STOP_CNT, 32'h0);
      wr(REG_CNT_LO, 32'd100);
      counters_in[95:64] <= 32'd99;
      arm(32'h203);
      quiet(trig_out, 12, "early cnt");
      counters_in[95:64] <= 32'd100;
      hit(trig_out, 20, "cnt trig");
      wr(8'h10, 32'h03);
      wr(8'h11, 32'h10000100);
      wr(8'h12, 32'h00010000);
      wr(REG_CTRL, 32'h10);
      smp(32'h0800);
      chk("lim below", 80'h0, do_out[0]);
      smp(32'h2000);
      chk("lim above", 80'h1, do_out[0]);
      chk("lim stat", 80'h1, ctl_stat_out[0]);
      smp(32'h0f80);
      chk("lim hyst", 80'h1, do_out[0]);
      smp(32'h0e00);
      chk("lim drop", 80'h0, do_out[0]);
      rd(REG_CTL_STAT);
      chk("stat read", 80'h0, r[0]);
      wr(REG_CTRL, 32'h1);
      for (i = 0; i < 2; i++)
      begin
         wr(REG_PERIOD, pv[i]);
         hit(update_out, 700, "tick");
         step();
         hit(update_out, 700, "tick");
         d1 = do_out;
         step();
         hit(update_out, 700, "tick");
         chk("spacing", pe[i], 80'(t + 1));
         chk("dma word", d1 + 16'h1, do_out);
         chk("ao lane", do_out, ao_out[15:0]);
      end
      wr(REG_PRE_CNT, 32'h2);
      for (i = 0; i < 2; i++)
      begin
         arm(32'h40 + 32'(i * 128));
         step();
         step();
         chk("pre store", 80'h1, store_out);
         smp(32'h1);
         stop_pulse();
         quiet(stop_out, 4, "pre early");
         smp(32'h1);
         stop_pulse();
         if (i == 0)
            hit(stop_out, 10, "pre stop");
         else
            quiet(stop_out, 10, "pre inf");
         wr(REG_CTRL, 32'h8);
         repeat (3) step();
         chk("pre end", 80'h0, store_out);
      end
      sys_rst_in <= 1'b1;
      step();
      chk("mid reset", 80'h0, {do_out, ao_out});
      give_verdict();
   end
endmodule
